// ---- bpp_top.sv ----
// Configurable output group: 32 sinking channels in 4 blocks of 8, with
// per-block period counters driving PWM and PPM slices, and bank writes.
// Assumes commands arrive on clk; pins are open drain and come in async.
`timescale 1ns/100ps
module bpp_top import bpp_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Channel command
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic [4:0] cmd_chan,
	input wire logic [1:0] cmd_func,
	input wire logic cmd_state,
	input wire logic cmd_freq_keep,
	input wire logic [15:0] cmd_limit,
	input wire logic cmd_invert,
	input wire logic [9:0] cmd_off_pm,
	input wire logic [9:0] cmd_duty_pm,
	input wire logic cmd_off_bind,
	input wire logic [2:0] cmd_off_src,
	input wire logic cmd_off_edge,
	input wire logic cmd_duty_bind,
	input wire logic [2:0] cmd_duty_src,
	input wire logic cmd_duty_edge,
	// Command answer
	output logic cmd_ack_ff,
	output logic cmd_perm_err_ff,
	output logic [7:0] cmd_conflict_ff,
	// Bank write
	input wire logic bank_wr,
	input wire logic [1:0] bank_sel,
	input wire logic [7:0] bank_data,
	// Block counter control
	input wire logic [3:0] blk_prescale_en,
	input wire logic cnt_reset,
	input wire logic [1:0] cnt_reset_blk,
	// Pins
	input wire logic [31:0] pin_i,
	output logic [31:0] pin_o_ff,
	output logic [31:0] pin_oe_n_ff,
	output logic [31:0] pin_level_ff
);
	logic [1:0] func_ff [NUM_CHAN];
	logic [31:0] dout_ff;
	logic [31:0] invert_ff;
	logic [9:0] off_pm_ff [NUM_CHAN];
	logic [9:0] duty_pm_ff [NUM_CHAN];
	logic [31:0] off_bind_ff;
	logic [31:0] duty_bind_ff;
	logic [2:0] off_src_ff [NUM_CHAN];
	logic [2:0] duty_src_ff [NUM_CHAN];
	logic [31:0] off_edge_ff;
	logic [31:0] duty_edge_ff;
	logic [15:0] pend_ff [NUM_BANK];
	logic [15:0] limit_ff [NUM_BANK];
	logic [15:0] count_ff [NUM_BANK];
	logic [7:0] presc_cnt_ff;
	logic presc_tick_ff;
	logic [31:0] pin_meta_ff;
	logic [31:0] pulse_mask;
	logic [31:0] digout_mask;
	logic [31:0] wave;
	logic [16:0] lead_pos [NUM_CHAN];
	logic [16:0] trail_pos [NUM_CHAN];
	logic [3:0] tick;
	logic [3:0] wrap;
	logic [3:0] blk_rst;
	logic [1:0] cmd_blk;
	logic cmd_pulse;
	logic perm_err;
	logic [7:0] conflict;
	logic accept;

	genvar gi;
	for (gi = 0; gi < NUM_CHAN; gi++) begin : g_mask
		assign pulse_mask[gi] = func_ff[gi] == FUNC_PWM || func_ff[gi] == FUNC_PPM;
		assign digout_mask[gi] = func_ff[gi] == FUNC_DIGOUT;
	end

	// Command checks
	assign cmd_blk = cmd_chan[4:3];
	assign cmd_pulse = cmd_func == FUNC_PWM || cmd_func == FUNC_PPM;

	always_comb begin
		perm_err = 1'b0;
		case (cmd_op)
			// no pulse on top two channels
			OP_CONFIG: perm_err = cmd_pulse && cmd_chan >= 5'(PULSE_CHANS);
			OP_DUTY, OP_FREQ: perm_err = !pulse_mask[cmd_chan];
			OP_OFFSET: perm_err = func_ff[cmd_chan] != FUNC_PPM;
			default: perm_err = 1'b1;
		endcase
	end

	always_comb begin
		conflict = '0;
		if (cmd_op == OP_CONFIG && cmd_pulse) begin
			if (cmd_off_bind && cmd_func == FUNC_PPM && !pulse_mask[{cmd_blk, cmd_off_src}]) begin
				conflict[cmd_off_src] = 1'b1;
			end
			if (cmd_duty_bind && !pulse_mask[{cmd_blk, cmd_duty_src}]) begin
				conflict[cmd_duty_src] = 1'b1;
			end
		end
	end
	assign accept = cmd_valid && !perm_err && conflict == 8'h00;
	// Answer strobes
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_ack_ff <= 1'b0;
			cmd_perm_err_ff <= 1'b0;
			cmd_conflict_ff <= '0;
		end else begin
			cmd_ack_ff <= accept;
			cmd_perm_err_ff <= cmd_valid && perm_err;
			cmd_conflict_ff <= (cmd_valid && !perm_err) ? conflict : 8'h00;
		end
	end

	// Channel configuration store
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				func_ff[i] <= FUNC_INPUT;
				off_pm_ff[i] <= '0;
				duty_pm_ff[i] <= '0;
				off_src_ff[i] <= '0;
				duty_src_ff[i] <= '0;
			end
			invert_ff <= '0;
			off_bind_ff <= '0;
			duty_bind_ff <= '0;
			off_edge_ff <= '0;
			duty_edge_ff <= '0;
		end else if (accept) begin
			case (cmd_op)
				OP_CONFIG: begin
					func_ff[cmd_chan] <= cmd_func;
					invert_ff[cmd_chan] <= cmd_invert;
					off_pm_ff[cmd_chan] <= cmd_off_pm;
					duty_pm_ff[cmd_chan] <= cmd_duty_pm;
					off_bind_ff[cmd_chan] <= cmd_off_bind && cmd_func == FUNC_PPM;
					off_src_ff[cmd_chan] <= cmd_off_src;
					off_edge_ff[cmd_chan] <= cmd_off_edge;
					duty_bind_ff[cmd_chan] <= cmd_duty_bind;
					duty_src_ff[cmd_chan] <= cmd_duty_src;
					duty_edge_ff[cmd_chan] <= cmd_duty_edge;
				end
				OP_DUTY: begin
					duty_pm_ff[cmd_chan] <= cmd_duty_pm;
					duty_bind_ff[cmd_chan] <= 1'b0;
				end
				OP_OFFSET: begin
					off_pm_ff[cmd_chan] <= cmd_off_pm;
					off_bind_ff[cmd_chan] <= 1'b0;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dout_ff <= '1;
		end else begin
			if (accept && cmd_op == OP_CONFIG && cmd_func == FUNC_DIGOUT) begin
				dout_ff[cmd_chan] <= cmd_state;
			end
			if (bank_wr) begin
				for (int b = 0; b < BANK_W; b++) begin
					// only sinking outputs follow the bank
					// D0 is the lowest channel of the bank
					if (digout_mask[{bank_sel, 3'(b)}]) begin
						dout_ff[{bank_sel, 3'(b)}] <= bank_data[b];
					end
				end
			end
		end
	end

	// Prescale enable pulse
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			presc_cnt_ff <= '0;
			presc_tick_ff <= 1'b0;
		end else begin
			presc_tick_ff <= presc_cnt_ff == PRESCALE_LAST;
			presc_cnt_ff <= (presc_cnt_ff == PRESCALE_LAST) ? 8'h00 : presc_cnt_ff + 8'h01;
		end
	end

	for (gi = 0; gi < NUM_BANK; gi++) begin : g_blk
		assign tick[gi] = blk_prescale_en[gi] ? presc_tick_ff : 1'b1;
		assign wrap[gi] = tick[gi] && count_ff[gi] == limit_ff[gi];
		assign blk_rst[gi] = cnt_reset && cnt_reset_blk == 2'(gi);

		// keep flag holds the pending period
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				pend_ff[gi] <= LIMIT_RST;
			end else if (accept && cmd_blk == 2'(gi)) begin
				if ((cmd_op == OP_CONFIG && cmd_pulse && !cmd_freq_keep) || cmd_op == OP_FREQ) begin
					pend_ff[gi] <= cmd_limit;
				end
			end
		end

		// period swaps at overflow or reset
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				limit_ff[gi] <= LIMIT_RST;
				count_ff[gi] <= '0;
			end else if (blk_rst[gi] || wrap[gi]) begin
				limit_ff[gi] <= pend_ff[gi];
				count_ff[gi] <= '0;
			end else if (tick[gi]) begin
				count_ff[gi] <= count_ff[gi] + 16'h0001;
			end
		end
	end

	for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
		if (gi < PULSE_CHANS) begin : g_pulse
			localparam int BLK = gi / BANK_W;
			logic [4:0] off_idx;
			logic [4:0] duty_idx;
			logic [16:0] off_bound;
			logic [16:0] duty_bound;
			assign off_idx = {2'(BLK), off_src_ff[gi]};
			assign duty_idx = {2'(BLK), duty_src_ff[gi]};
			// partner edge picked by edge select
			assign off_bound = (off_edge_ff[gi] == BIND_TO_TRAILING_EDGE) ?
				trail_pos[off_idx] : lead_pos[off_idx];
			assign duty_bound = (duty_edge_ff[gi] == BIND_TO_TRAILING_EDGE) ?
				trail_pos[duty_idx] : lead_pos[duty_idx];

			bpp_chan u_chan (
				.clk(clk),
				.sys_rst(sys_rst),
				.pulse_en(pulse_mask[gi]),
				.ppm_mode(func_ff[gi] == FUNC_PPM),
				.invert(invert_ff[gi]),
				.off_pm(off_pm_ff[gi]),
				.duty_pm(duty_pm_ff[gi]),
				.off_bind(off_bind_ff[gi]),
				.off_bound_pos(off_bound),
				.duty_bind(duty_bind_ff[gi]),
				.duty_bound_pos(duty_bound),
				.period({1'b0, limit_ff[BLK]} + 17'h00001),
				.count(count_ff[BLK]),
				.lead_pos_ff(lead_pos[gi]),
				.trail_pos_ff(trail_pos[gi]),
				.wave_ff(wave[gi])
			);
		end else begin : g_plain
			assign lead_pos[gi] = '0;
			assign trail_pos[gi] = '0;
			assign wave[gi] = 1'b1;
		end
	end

	// low level sinks, high level floats
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_oe_n_ff <= '1;
			pin_o_ff <= '0;
		end else begin
			pin_o_ff <= '0;
			for (int i = 0; i < NUM_CHAN; i++) begin
				case (func_ff[i])
					FUNC_DIGOUT: pin_oe_n_ff[i] <= dout_ff[i];
					FUNC_PWM, FUNC_PPM: pin_oe_n_ff[i] <= wave[i];
					default: pin_oe_n_ff[i] <= 1'b1;
				endcase
			end
		end
	end

	// Pin levels cross in through two stages
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta_ff <= '1;
			pin_level_ff <= '1;
		end else begin
			pin_meta_ff <= pin_i;
			pin_level_ff <= pin_meta_ff;
		end
	end

	property p_bank_others;
		@(posedge clk) disable iff (sys_rst)
		bank_wr && !(accept && cmd_op == OP_CONFIG) |=>
			(dout_ff & ~$past(digout_mask)) == $past(dout_ff & ~digout_mask);
	endproperty
	a_bank_others: assert property (p_bank_others) else $error("bank write hit other function");
	property p_bank_bit0;
		@(posedge clk) disable iff (sys_rst)
		bank_wr && digout_mask[{bank_sel, 3'h0}] |=>
			dout_ff[{$past(bank_sel), 3'h0}] == $past(bank_data[0]);
	endproperty
	a_bank_bit0: assert property (p_bank_bit0) else $error("bank bit order wrong");
	property p_sink_level;
		@(posedge clk) disable iff (sys_rst)
		digout_mask[0] ##1 digout_mask[0] |-> pin_oe_n_ff[0] == $past(dout_ff[0]);
	endproperty
	a_sink_level: assert property (p_sink_level) else $error("sink pin level wrong");
	property p_top_refuse;
		@(posedge clk) disable iff (sys_rst)
		cmd_valid && cmd_op == OP_CONFIG && cmd_chan >= 5'h1E && cmd_func[1] |=>
			cmd_perm_err_ff && !cmd_ack_ff;
	endproperty
	a_top_refuse: assert property (p_top_refuse) else $error("pulse mode accepted on top pair");
	property p_keep_freq;
		@(posedge clk) disable iff (sys_rst)
		cmd_valid && cmd_op == OP_CONFIG && cmd_freq_keep |=> $stable(pend_ff[0])
			&& $stable(pend_ff[1]) && $stable(pend_ff[2]) && $stable(pend_ff[3]);
	endproperty
	a_keep_freq: assert property (p_keep_freq) else $error("kept frequency changed");
	property p_limit_swap;
		@(posedge clk) disable iff (sys_rst)
		!wrap[0] && !blk_rst[0] |=> $stable(limit_ff[0]);
	endproperty
	a_limit_swap: assert property (p_limit_swap) else $error("period changed mid period");
	property p_conflict_ack;
		@(posedge clk) disable iff (sys_rst)
		cmd_conflict_ff != 8'h00 |-> !cmd_ack_ff && !cmd_perm_err_ff;
	endproperty
	a_conflict_ack: assert property (p_conflict_ack) else $error("conflict with ack");
	c_bank_write: cover property (@(posedge clk) disable iff (sys_rst) bank_wr && digout_mask != 0);
	c_conflict: cover property (@(posedge clk) disable iff (sys_rst) cmd_conflict_ff != 8'h00);
	c_wrap_swap: cover property (@(posedge clk) disable iff (sys_rst)
		wrap[0] && pend_ff[0] != limit_ff[0]);
endmodule

// ---- bpp_pkg.sv ----
// Constants and encodings shared by the pulse output block and its channel slices.
// Assumes one 100 MHz clock; all widths fixed.
package bpp_pkg;
	localparam int NUM_CHAN = 32;
	localparam int NUM_BANK = 4;
	localparam int BANK_W = 8;
	localparam int PULSE_CHANS = 30;
	localparam int CLK_HZ = 100000000;
	// Request range kept by the configuring party
	localparam int FREQ_MIN_HZ = 2;
	localparam int FREQ_MAX_HZ = 50000;

	// Duty and offset are given in tenths of a percent
	localparam logic [9:0] PM_FULL = 10'h3E8;
	localparam logic [26:0] PM_DIV = 27'h00003E8;
	localparam logic [16:0] PPM_MIN_LEAD = 17'h00001;

	localparam logic [15:0] LIMIT_RST = 16'hFFFF;
	localparam logic [7:0] PRESCALE_DIV = 8'h10;
	localparam logic [7:0] PRESCALE_LAST = PRESCALE_DIV - 8'h01;

	typedef enum logic [1:0] {
		FUNC_INPUT = 2'h0,
		FUNC_DIGOUT = 2'h1,
		FUNC_PWM = 2'h2,
		FUNC_PPM = 2'h3
	} bpp_func_type;

	typedef enum logic [1:0] {
		OP_CONFIG = 2'h0,
		OP_DUTY = 2'h1,
		OP_OFFSET = 2'h2,
		OP_FREQ = 2'h3
	} bpp_op_type;

	localparam logic BIND_TO_LEADING_EDGE = 1'b0;
	localparam logic BIND_TO_TRAILING_EDGE = 1'b1;
endpackage

// ---- bpp_chan.sv ----
// One pulse channel slice: edge positions and waveform against the block count.
// Assumes count and period come from the owning block on the same clock.
`timescale 1ns/100ps
module bpp_chan import bpp_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Configuration
	input wire logic pulse_en,
	input wire logic ppm_mode,
	input wire logic invert,
	input wire logic [9:0] off_pm,
	input wire logic [9:0] duty_pm,
	input wire logic off_bind,
	input wire logic [16:0] off_bound_pos,
	input wire logic duty_bind,
	input wire logic [16:0] duty_bound_pos,
	// Block counter
	input wire logic [16:0] period,
	input wire logic [15:0] count,
	// Results
	output logic [16:0] lead_pos_ff,
	output logic [16:0] trail_pos_ff,
	output logic wave_ff
);
	logic [16:0] nxt_lead;
	logic [16:0] nxt_trail;
	logic [17:0] trail_sum;
	logic active;

	function automatic logic [16:0] scale(input logic [16:0] p, input logic [9:0] pm);
		logic [9:0] c;
		logic [26:0] prod;
		c = (pm > PM_FULL) ? PM_FULL : pm;
		prod = 27'(p) * 27'(c);
		return 17'(prod / PM_DIV);
	endfunction

	always_comb begin
		nxt_lead = '0;
		if (ppm_mode) begin
			if (off_bind) begin
				nxt_lead = (off_bound_pos > period) ? period : off_bound_pos;
			end else if (scale(period, off_pm) < PPM_MIN_LEAD) begin
				nxt_lead = PPM_MIN_LEAD;
			end else begin
				nxt_lead = scale(period, off_pm);
			end
		end
	end

	always_comb begin
		trail_sum = {1'b0, nxt_lead} + {1'b0, scale(period, duty_pm)};
		if (duty_bind) begin
			trail_sum = {1'b0, duty_bound_pos};
		end
		nxt_trail = (trail_sum > {1'b0, period}) ? period : trail_sum[16:0];
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lead_pos_ff <= '0;
			trail_pos_ff <= '0;
		end else begin
			lead_pos_ff <= nxt_lead;
			trail_pos_ff <= nxt_trail;
		end
	end

	assign active = ({1'b0, count} >= lead_pos_ff) && ({1'b0, count} < trail_pos_ff);

	// pulse level first in PWM, after the offset in PPM, flipped by invert
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wave_ff <= 1'b1;
		end else begin
			wave_ff <= pulse_en ? (active ^ invert) : 1'b1;
		end
	end

	property p_lead_floor;
		@(posedge clk) disable iff (sys_rst)
		ppm_mode && !off_bind |=> lead_pos_ff >= PPM_MIN_LEAD;
	endproperty
	a_lead_floor: assert property (p_lead_floor) else $error("ppm lead below one count");

	property p_trail_cap;
		@(posedge clk) disable iff (sys_rst)
		1'b1 |=> trail_pos_ff <= $past(period);
	endproperty
	a_trail_cap: assert property (p_trail_cap) else $error("trailing edge past period");

	property p_duty_clamp;
		@(posedge clk) disable iff (sys_rst)
		!ppm_mode && !duty_bind && duty_pm > PM_FULL |=> trail_pos_ff == $past(period);
	endproperty
	a_duty_clamp: assert property (p_duty_clamp) else $error("duty not clamped to full");

	property p_pwm_start;
		@(posedge clk) disable iff (sys_rst)
		pulse_en && !ppm_mode && count == 16'h0000 && lead_pos_ff == 17'h00000
			&& trail_pos_ff != 17'h00000 |=> wave_ff == !$past(invert);
	endproperty
	a_pwm_start: assert property (p_pwm_start) else $error("pwm period start level wrong");

	property p_ppm_before_offset;
		@(posedge clk) disable iff (sys_rst)
		pulse_en && ppm_mode && {1'b0, count} < lead_pos_ff |=> wave_ff == $past(invert);
	endproperty
	a_ppm_before_offset: assert property (p_ppm_before_offset) else $error("ppm early level wrong");

	c_ppm_pulse: cover property (@(posedge clk) disable iff (sys_rst)
		pulse_en && ppm_mode && !invert && !wave_ff ##1 wave_ff);
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the pulse output group: command answers, bank writes,
// waveform duty, binding and period handling, measured at the open-drain pins.
// Assumes pins have pull-ups; inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
module tb_top import bpp_pkg::*;;
	typedef struct packed {
		logic [1:0] op;
		logic [4:0] ch;
		logic [1:0] fn;
		logic st;
		logic kp;
		logic [15:0] lim;
		logic inv;
		logic [9:0] off;
		logic [9:0] duty;
		logic ob;
		logic [2:0] os;
		logic oe;
		logic db;
		logic [2:0] ds;
		logic de;
	} bpp_cmd_type;
	typedef struct packed {
		bpp_cmd_type c;
		logic [1:0] kind;
		logic [7:0] map;
	} bpp_row_type;

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_valid = 1'b0;
	bpp_cmd_type cur = '0;
	logic bank_wr = 1'b0;
	logic [1:0] bank_sel = 2'h0;
	logic [7:0] bank_data = 8'h00;
	logic [3:0] blk_prescale_en = 4'h0;
	logic cnt_reset = 1'b0;
	logic [1:0] cnt_reset_blk = 2'h0;
	logic [31:0] ext_low = 32'h00000000;
	logic [31:0] pin_i;
	logic cmd_ack_ff, cmd_perm_err_ff;
	logic [7:0] cmd_conflict_ff;
	logic [31:0] pin_o_ff, pin_oe_n_ff, pin_level_ff;
	int bad_count = 0;
	int compares = 0;
	int hi[32];
	int mis_c, mis_e, i;
	bpp_row_type rows[8];
	logic [41:0] banks[4];
	int b0_off[8] = '{500, 0, 0, 500, 0, 250, 0, 1023};
	int b0_duty[8] = '{300, 500, 500, 300, 1000, 900, 1023, 100};
	logic [7:0] b0_ppm = 8'hB9;
	logic [7:0] b0_inv = 8'h05;
	bpp_cmd_type c;

	// Open drain with pull-up; ext_low models an outside load pulling low
	assign pin_i = pin_oe_n_ff & ~ext_low;

	always #5 clk = ~clk;

	bpp_top u_dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cur.op),
		.cmd_chan(cur.ch), .cmd_func(cur.fn), .cmd_state(cur.st), .cmd_freq_keep(cur.kp),
		.cmd_limit(cur.lim), .cmd_invert(cur.inv), .cmd_off_pm(cur.off),
		.cmd_duty_pm(cur.duty), .cmd_off_bind(cur.ob), .cmd_off_src(cur.os),
		.cmd_off_edge(cur.oe), .cmd_duty_bind(cur.db), .cmd_duty_src(cur.ds),
		.cmd_duty_edge(cur.de), .cmd_ack_ff(cmd_ack_ff), .cmd_perm_err_ff(cmd_perm_err_ff),
		.cmd_conflict_ff(cmd_conflict_ff), .bank_wr(bank_wr), .bank_sel(bank_sel),
		.bank_data(bank_data), .blk_prescale_en(blk_prescale_en), .cnt_reset(cnt_reset),
		.cnt_reset_blk(cnt_reset_blk), .pin_i(pin_i), .pin_o_ff(pin_o_ff),
		.pin_oe_n_ff(pin_oe_n_ff), .pin_level_ff(pin_level_ff));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk_vec(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_cnt(input string name, input int exp, input int got);
		compares++;
		if (got != exp) begin
			bad_count++;
			$display("unexpected %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	function automatic bpp_cmd_type cfg(input logic [4:0] ch, input logic [1:0] fn,
		input logic inv, input logic [9:0] off, input logic [9:0] duty, input logic kp);
		bpp_cmd_type r;
		r = '0;
		r.op = OP_CONFIG;
		r.ch = ch;
		r.fn = fn;
		r.st = inv;
		r.inv = inv;
		r.off = off;
		r.duty = duty;
		r.kp = kp;
		// Period 2000 counts is 50 kHz, top of the allowed request range
		r.lim = 16'h07CF;
		return r;
	endfunction

	function automatic bpp_cmd_type opc(input logic [1:0] op, input logic [4:0] ch,
		input logic [9:0] off, input logic [9:0] duty);
		bpp_cmd_type r;
		r = cfg(ch, FUNC_INPUT, 1'b0, off, duty, 1'b1);
		r.op = op;
		return r;
	endfunction

	// High cycles of a released pin over one period, from the count rules
	function automatic int exp_hi(input bit ppm, input bit inv, input int off, input int duty,
		input int p);
		int ld, tr;
		off = (off > 1000) ? 1000 : off;
		duty = (duty > 1000) ? 1000 : duty;
		ld = ppm ? p * off / 1000 : 0;
		if (ppm && ld < 1) ld = 1;
		tr = ld + p * duty / 1000;
		if (tr > p) tr = p;
		return inv ? p - (tr - ld) : tr - ld;
	endfunction

	task automatic send(input bpp_cmd_type x, input logic [1:0] kind, input logic [7:0] map);
		@(posedge clk);
		#1;
		cur = x;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		chk_vec("ack", {31'h0, kind == 2'h0}, {31'h0, cmd_ack_ff});
		chk_vec("perm_err", {31'h0, kind == 2'h1}, {31'h0, cmd_perm_err_ff});
		chk_vec("conflict", {24'h0, map}, {24'h0, cmd_conflict_ff});
	endtask

	task automatic restart(input logic [1:0] blk);
		@(posedge clk);
		#1;
		cnt_reset = 1'b1;
		cnt_reset_blk = blk;
		@(posedge clk);
		#1;
		cnt_reset = 1'b0;
		repeat (20) @(posedge clk);
	endtask

	task automatic meas(input int n);
		logic [31:0] prev;
		int j, k;
		hi = '{default: 0};
		mis_c = 0;
		mis_e = 0;
		@(posedge clk);
		#1;
		prev = pin_oe_n_ff;
		for (j = 0; j < n; j++) begin
			@(posedge clk);
			#1;
			for (k = 0; k < 32; k++) if (pin_oe_n_ff[k] === 1'b1) hi[k]++;
			if (pin_oe_n_ff[2] !== ~pin_oe_n_ff[1] || pin_oe_n_ff[0] !== ~pin_oe_n_ff[3]) mis_c++;
			if ((prev[1] & ~pin_oe_n_ff[1]) !== (~prev[3] & pin_oe_n_ff[3])) mis_e++;
			prev = pin_oe_n_ff;
		end
	endtask

	task automatic chk_hi(input int base, input int n, input int e[8]);
		int k;
		for (k = 0; k < n; k++) chk_cnt($sformatf("high_cycles_%0d", base + k), e[k], hi[base + k]);
	endtask

	initial begin
		repeat (80000) @(posedge clk);
		bad_count++;
		$display("unexpected watchdog expected done seen hang");
		end_sim();
	end

	initial begin
		rows[0] = '{cfg(30, FUNC_PWM, 0, 0, 500, 1), 2'h1, 8'h00};
		rows[1] = '{cfg(31, FUNC_PPM, 0, 0, 500, 1), 2'h1, 8'h00};
		rows[2] = '{cfg(29, FUNC_PWM, 0, 0, 500, 1), 2'h0, 8'h00};
		rows[3] = '{cfg(30, FUNC_DIGOUT, 0, 0, 0, 1), 2'h0, 8'h00};
		rows[4] = '{opc(OP_DUTY, 30, 0, 500), 2'h1, 8'h00};
		rows[5] = '{opc(OP_OFFSET, 29, 500, 0), 2'h1, 8'h00};
		c = cfg(2, FUNC_PWM, 0, 0, 0, 1);
		c.db = 1'b1;
		c.ds = 3'h5;
		rows[6] = '{c, 2'h2, 8'h20};
		c = cfg(3, FUNC_PPM, 0, 0, 0, 1);
		{c.ob, c.os, c.db, c.ds} = {1'b1, 3'h6, 1'b1, 3'h7};
		rows[7] = '{c, 2'h2, 8'hC0};
		banks[0] = {2'h1, 8'h7A, 32'h00007800};
		banks[1] = {2'h1, 8'h05, 32'h00007D00};
		banks[2] = {2'h3, 8'h40, 32'hC0000000};
		banks[3] = {2'h3, 8'h00, 32'h80000000};
		repeat (19) @(posedge clk);
		#1;
		chk_vec("oe_n_reset", 32'hFFFFFFFF, pin_oe_n_ff);
		chk_vec("level_reset", 32'hFFFFFFFF, pin_level_ff);
		chk_vec("ack_reset", 32'h0, {cmd_conflict_ff, cmd_perm_err_ff, cmd_ack_ff});
		@(posedge clk);
		#1;
		sys_rst = 1'b0;
		for (i = 0; i < 8; i++) send(rows[i].c, rows[i].kind, rows[i].map);
		// Banked sinking outputs beside a pulse channel and a plain input
		send(cfg(8, FUNC_DIGOUT, 1, 0, 0, 1), 2'h0, 8'h00);
		send(cfg(10, FUNC_DIGOUT, 0, 0, 0, 1), 2'h0, 8'h00);
		send(cfg(15, FUNC_DIGOUT, 1, 0, 0, 1), 2'h0, 8'h00);
		send(cfg(9, FUNC_PWM, 1, 0, 1000, 1), 2'h0, 8'h00);
		ext_low = 32'h00000800;
		repeat (10) @(posedge clk);
		chk_vec("bank1_config", 32'h0000F900, pin_oe_n_ff & 32'h0000FF00);
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			#1;
			{bank_sel, bank_data} = banks[i][41:32];
			bank_wr = 1'b1;
			@(posedge clk);
			#1;
			bank_wr = 1'b0;
			repeat (4) @(posedge clk);
			chk_vec("bank_write", banks[i][31:0], pin_oe_n_ff & (i < 2 ? 32'h0000FF00 : 32'hC0000000));
		end
		chk_vec("pin_level", 32'h00007500, pin_level_ff & 32'h0000FF00);
		// Block 0: every waveform shape side by side
		for (i = 0; i < 8; i++) begin
			send(cfg(i, b0_ppm[i] ? FUNC_PPM : FUNC_PWM, b0_inv[i], b0_off[i], b0_duty[i], 0), 2'h0, 8'h00);
		end
		restart(2'h0);
		meas(2000);
		for (i = 0; i < 8; i++) begin
			chk_cnt("block0_high", exp_hi(b0_ppm[i], b0_inv[i], b0_off[i], b0_duty[i], 2000), hi[i]);
		end
		chk_cnt("inverted_mirror", 0, mis_c);
		chk_cnt("pwm_fall_ppm_rise", 0, mis_e);
		// Block 2: chained bindings
		send(cfg(16, FUNC_PWM, 0, 0, 300, 0), 2'h0, 8'h00);
		c = cfg(17, FUNC_PWM, 0, 0, 0, 1);
		{c.db, c.ds, c.de} = {1'b1, 3'h0, BIND_TO_TRAILING_EDGE};
		send(c, 2'h0, 8'h00);
		c = cfg(18, FUNC_PPM, 0, 0, 200, 1);
		{c.ob, c.os, c.oe} = {1'b1, 3'h0, BIND_TO_TRAILING_EDGE};
		send(c, 2'h0, 8'h00);
		c = cfg(19, FUNC_PPM, 0, 100, 0, 1);
		{c.db, c.ds, c.de} = {1'b1, 3'h2, BIND_TO_TRAILING_EDGE};
		send(c, 2'h0, 8'h00);
		c = cfg(20, FUNC_PPM, 0, 0, 100, 1);
		{c.ob, c.os, c.oe} = {1'b1, 3'h3, BIND_TO_LEADING_EDGE};
		send(c, 2'h0, 8'h00);
		restart(2'h2);
		meas(2000);
		chk_hi(16, 5, '{600, 600, 400, 800, 200, 0, 0, 0});
		send(opc(OP_DUTY, 16, 0, 500), 2'h0, 8'h00);
		repeat (20) @(posedge clk);
		meas(2000);
		chk_hi(16, 5, '{1000, 1000, 400, 1200, 200, 0, 0, 0});
		send(opc(OP_OFFSET, 18, 100, 0), 2'h0, 8'h00);
		repeat (20) @(posedge clk);
		meas(2000);
		chk_hi(16, 5, '{1000, 1000, 400, 400, 200, 0, 0, 0});
		c = opc(OP_FREQ, 16, 0, 0);
		c.lim = 16'h0F9F;
		send(c, 2'h0, 8'h00);
		c = cfg(21, FUNC_PWM, 0, 0, 250, 1);
		c.lim = 16'h0009;
		send(c, 2'h0, 8'h00);
		// Natural wrap, no counter reset, must pick up the new period
		repeat (2100) @(posedge clk);
		meas(4000);
		chk_hi(16, 6, '{2000, 2000, 800, 800, 400, 1000, 0, 0});
		// Block 3 on the prescaled clock
		blk_prescale_en = 4'h8;
		send(cfg(25, FUNC_PWM, 0, 0, 500, 0), 2'h0, 8'h00);
		restart(2'h3);
		meas(32000);
		chk_hi(25, 1, '{16000, 0, 0, 0, 0, 0, 0, 0});
		chk_hi(29, 1, '{16000, 0, 0, 0, 0, 0, 0, 0});
		chk_vec("pin_o", 32'h0, pin_o_ff);
		// Second reset in mid-run
		@(posedge clk);
		#1;
		sys_rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk_vec("oe_n_rerst", 32'hFFFFFFFF, pin_oe_n_ff);
		sys_rst = 1'b0;
		send(cfg(31, FUNC_PWM, 0, 0, 500, 1), 2'h1, 8'h00);
		send(cfg(1, FUNC_DIGOUT, 0, 0, 0, 1), 2'h0, 8'h00);
		repeat (6) @(posedge clk);
		chk_vec("sink_after_rst", 32'hFFFFFFFD, pin_oe_n_ff);
		end_sim();
	end
endmodule
